/* hdl/ccg_pkg.sv */
// Constants for the clock generation control block.
// Assumes an APB master with 32-bit data; registers sit at four times their index.
package ccg_pkg;

    // ----------------------------------------
    // Register indices and address width
    // ----------------------------------------
    localparam logic [15:0] CCG_IDX_DIVMODE = 16'hf002;
    localparam logic [15:0] CCG_IDX_OSCSEL  = 16'hf003;
    localparam logic [15:0] CCG_IDX_STATUS  = 16'hf070;
    localparam logic [15:0] CCG_IDX_INTSTAT = 16'hf071;
    localparam logic [15:0] CCG_IDX_INTMASK = 16'hf072;
    localparam int          CCG_AW          = 18;

    // ----------------------------------------
    // Reset values and field positions
    // ----------------------------------------
    localparam logic [7:0] CCG_RST_DIVMODE = 8'h3b;
    localparam logic [7:0] CCG_RST_OSCSEL  = 8'h83;
    localparam logic [7:0] CCG_RST_STATUS  = 8'h04;
    localparam int CCG_F_HSDIV   = 0;
    localparam int CCG_F_MODE    = 2;
    localparam int CCG_F_OUTDIV  = 4;
    localparam int CCG_B_SYSSEL  = 0;
    localparam int CCG_B_HSEN    = 1;
    localparam int CCG_B_PLLRDY  = 7;
    localparam int CCG_B_LSFLAG  = 2;
    localparam int CCG_B_EV_LS   = 0;
    localparam int CCG_B_EV_HS   = 1;

    // ----------------------------------------
    // Oscillator modes and counts
    // ----------------------------------------
    localparam logic [1:0] CCG_MODE_BAD  = 2'h0;
    localparam logic [1:0] CCG_MODE_XTAL = 2'h1;
    localparam logic [1:0] CCG_MODE_PLL  = 2'h2;
    localparam logic [1:0] CCG_MODE_EXT  = 2'h3;
    localparam logic [1:0] CCG_DIV_1     = 2'h0;
    localparam logic [1:0] CCG_DIV_2     = 2'h1;
    localparam int CCG_STAB_EXT  = 128;
    localparam int CCG_STAB_XTAL = 4096;
    localparam int CCG_STAB_PLL  = 8192;
    localparam int CCG_LS_RC     = 128;
    localparam int CCG_LS_XTAL   = 8192;
    localparam logic [2:0] CCG_PLL_PREDIV = 3'h7;
    localparam logic [9:0] CCG_PLL_MULT   = 10'h1f4;

    typedef enum logic [1:0] {
        CCG_LS_RC_WAIT,
        CCG_LS_RC_RUN,
        CCG_LS_XTAL_RUN
    } ccg_ls_state_type;

endpackage

/* hdl/ccg_div_if.sv */
// Tick divider link between the control block and one divider.
// Assumes both ends share ref_clk_in.
`timescale 1ns/1ps
interface ccg_div_if;
    logic       tick;
    logic [1:0] sel;
    logic       out;
    modport ctrl (output tick, output sel, input out);
    modport div  (input tick, input sel, output out);
endinterface

/* hdl/ccg_divider.sv */
// Divides a tick stream by 1, 2, 4 or 8.
// Assumes one-cycle input ticks; selection is taken only at a period boundary.
`timescale 1ns/1ps
module ccg_divider
    import ccg_pkg::*;
(
    input  wire logic ref_clk_in,
    input  wire logic sys_rst_in,
    ccg_div_if.div    link
);

    logic [2:0] cnt_q;
    logic [1:0] sel_q;
    logic       wrap;
    logic [2:0] mask;

    always_comb begin
        mask = 3'h7 >> (2'h3 - sel_q);
        wrap = link.tick && ((cnt_q & mask) == mask);
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            cnt_q <= 3'h0;
        end else if (wrap) begin
            cnt_q <= 3'h0;
        end else if (link.tick) begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    // R18: switch at boundary
    // A new ratio mid-period would cut a short pulse
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            sel_q <= 2'h3;
        end else if (wrap || !link.tick && cnt_q == 3'h0) begin
            sel_q <= link.sel;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            link.out <= 1'b0;
        end else begin
            link.out <= wrap;
        end
    end

endmodule

/* hdl/ccg_top.sv */
// Clock generation control: registers, oscillator sequencing, clock ticks.
// Assumes oscillator sources arrive as one-cycle ticks synchronous to ref_clk_in.
//
// How it works
// R1: High-speed clock is oscillation clock over 1, 2, 4 or 8; resets to 8.
// R2: Divider code 00 in PLL mode gives half the oscillation clock.
// R3: Mode field: 01 crystal, 10 PLL (reset), 11 external; 00 forbidden.
// R4: Mode field changes only while high-speed oscillation is disabled.
// R5: Port output clock is oscillation clock over 1, 2, 4 or 8; resets to 8.
// R6: System select bit 0: zero low-speed, one high-speed; resets one.
// R7: With oscillation disabled, select bit is held zero, low-speed used.
// R8: Enable bit 1 stops or runs the high-speed oscillator; resets one.
// R9: Read-only bit 7 shows one once oscillation clock supply has begun.
// R10: After reset oscillation clock is PLL over 8, high-speed a further 8.
// R11: Low-speed flag bit 2 clears together with the change interrupt.
// R12: Stop entry sets the low-speed flag with no interrupt.
// R13: Software leaves high-speed mode and disables oscillation before mode change.
// R14: Oscillation clock waits 128, 8192 or 4096 pulses by mode.
// R15: RC clock after 128 counts; crystal after 8192, raising the interrupt.
// R16: PLL runs at low-speed clock times 500.
// R17: Stop halts oscillation; leaving restarts it behind the stabilization count.
// R18: Source and ratio changes never make truncated clock pulses.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module ccg_top
    import ccg_pkg::*;
#(
    parameter int STAB_PLL  = CCG_STAB_PLL,
    parameter int STAB_XTAL = CCG_STAB_XTAL,
    parameter int LS_XTAL   = CCG_LS_XTAL
)(
    input  wire logic              ref_clk_in,
    input  wire logic              sys_rst_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [CCG_AW-1:0] paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output logic [31:0]            prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    input  wire logic              stop_mode_in,
    input  wire logic              pll_tick_in,
    input  wire logic              xtal_hs_tick_in,
    input  wire logic              ext_tick_in,
    input  wire logic              rc_tick_in,
    input  wire logic              xtal_ls_tick_in,
    output logic                   hs_osc_run_out,
    output logic                   pll_en_out,
    output logic [9:0]             pll_mult_out,
    output logic                   osc_tick_out,
    output logic                   hs_tick_out,
    output logic                   out_tick_out,
    output logic                   ls_tick_out,
    output logic                   sys_tick_out,
    output logic                   irq_out
);

    // ----------------------------------------
    // Registers and state
    // ----------------------------------------
    logic [1:0] hs_div_q, mode_q, out_div_q;
    logic       hs_en_q, syssel_q, sys_src_q, osc_ready_q, ls_flag_q, stop_q;
    logic [1:0] int_stat_q, int_mask_q;
    logic [13:0] stab_cnt_q, ls_cnt_q;
    logic [2:0]  pre_cnt_q;
    ccg_ls_state_type ls_state_q;
    ccg_div_if hs_link ();
    ccg_div_if out_link ();

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic        setup, wr, rd_stat, ev_ls, ev_hs, src_tick, osc_pulse, run;
    logic [15:0] idx;
    logic [13:0] stab_need;
    logic        hit;
    logic [7:0]  rdata;

    assign idx   = paddr_in[17:2];
    assign setup = psel_in && !penable_in;
    assign wr    = psel_in && penable_in && pready_out && pwrite_in && hit;
    assign rd_stat = psel_in && penable_in && pready_out && !pwrite_in
                     && idx == CCG_IDX_INTSTAT;

    always_comb begin
        hit   = 1'b1;
        rdata = 8'h00;
        case (idx)
            CCG_IDX_DIVMODE: rdata = {2'h0, out_div_q, mode_q, hs_div_q};
            // R9: ready flag readback
            CCG_IDX_OSCSEL:  rdata = {osc_ready_q, 5'h00, hs_en_q, syssel_q};
            CCG_IDX_STATUS:  rdata = {5'h00, ls_flag_q, 2'h0};
            CCG_IDX_INTSTAT: rdata = {6'h00, int_stat_q};
            CCG_IDX_INTMASK: rdata = {6'h00, int_mask_q};
            default:         hit = 1'b0;
        endcase
    end

    // Zero-wait: answer prepared in setup, access ends on its first edge
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end else begin
            pready_out  <= setup;
            pslverr_out <= setup && !hit;
            prdata_out  <= setup && !pwrite_in ? {24'h00_0000, rdata} : 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            hs_div_q  <= CCG_RST_DIVMODE[CCG_F_HSDIV+:2];
            mode_q    <= CCG_RST_DIVMODE[CCG_F_MODE+:2];
            out_div_q <= CCG_RST_DIVMODE[CCG_F_OUTDIV+:2];
        end else if (wr && idx == CCG_IDX_DIVMODE) begin
            // R1: high-speed ratio
            hs_div_q  <= pwdata_in[CCG_F_HSDIV+:2];
            // R5: port output ratio
            out_div_q <= pwdata_in[CCG_F_OUTDIV+:2];
            // R3: forbidden code kept out
            // R4: mode locked while running
            // R13: software stops oscillation first
            if (!hs_en_q && pwdata_in[CCG_F_MODE+:2] != CCG_MODE_BAD) begin
                mode_q <= pwdata_in[CCG_F_MODE+:2];
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            hs_en_q  <= CCG_RST_OSCSEL[CCG_B_HSEN];
            syssel_q <= CCG_RST_OSCSEL[CCG_B_SYSSEL];
        end else if (wr && idx == CCG_IDX_OSCSEL) begin
            // R8: oscillator enable
            hs_en_q  <= pwdata_in[CCG_B_HSEN];
            // R6: system source select
            // R7: held low while disabled
            syssel_q <= pwdata_in[CCG_B_SYSSEL] && pwdata_in[CCG_B_HSEN];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            int_mask_q <= 2'h0;
        end else if (wr && idx == CCG_IDX_INTMASK) begin
            int_mask_q <= pwdata_in[1:0];
        end
    end

    // ----------------------------------------
    // High-speed oscillation sequencing
    // ----------------------------------------
    // R17: stop halts oscillator
    assign run = hs_en_q && !stop_q;

    always_comb begin
        case (mode_q)
            CCG_MODE_XTAL: begin
                src_tick  = xtal_hs_tick_in;
                stab_need = 14'(STAB_XTAL);
            end
            CCG_MODE_EXT: begin
                src_tick  = ext_tick_in;
                stab_need = 14'(CCG_STAB_EXT);
            end
            default: begin
                src_tick  = pll_tick_in;
                stab_need = 14'(STAB_PLL);
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            stop_q <= 1'b0;
        end else begin
            stop_q <= stop_mode_in;
        end
    end

    // R14: stabilization count
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            stab_cnt_q  <= 14'h0000;
            osc_ready_q <= CCG_RST_OSCSEL[CCG_B_PLLRDY];
        end else if (!run) begin
            stab_cnt_q  <= 14'h0000;
            osc_ready_q <= 1'b0;
        end else if (!osc_ready_q && src_tick) begin
            stab_cnt_q  <= stab_cnt_q + 14'h0001;
            osc_ready_q <= stab_cnt_q + 14'h0001 >= stab_need;
        end
    end

    // R10: PLL predivide by eight
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || !run) begin
            pre_cnt_q <= 3'h0;
        end else if (src_tick) begin
            pre_cnt_q <= pre_cnt_q + 3'h1;
        end
    end

    assign osc_pulse = osc_ready_q && src_tick
                       && (mode_q != CCG_MODE_PLL || pre_cnt_q == CCG_PLL_PREDIV);
    assign ev_hs     = run && !osc_ready_q && src_tick && stab_cnt_q + 14'h0001 >= stab_need;

    // R2: undivided code halves in PLL mode
    assign hs_link.sel  = (hs_div_q == CCG_DIV_1 && mode_q == CCG_MODE_PLL) ? CCG_DIV_2
                                                                             : hs_div_q;
    assign hs_link.tick = osc_pulse;
    assign out_link.sel  = out_div_q;
    assign out_link.tick = osc_pulse;

    ccg_divider u_hs_div (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .link       (hs_link.div)
    );

    ccg_divider u_out_div (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .link       (out_link.div)
    );

    // ----------------------------------------
    // Low-speed clock sequencing
    // ----------------------------------------
    // R15: RC then crystal
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || stop_q) begin
            ls_state_q <= CCG_LS_RC_WAIT;
            ls_cnt_q   <= 14'h0000;
        end else begin
            case (ls_state_q)
                CCG_LS_RC_WAIT: if (rc_tick_in) begin
                    ls_cnt_q <= ls_cnt_q + 14'h0001;
                    if (ls_cnt_q + 14'h0001 >= 14'(CCG_LS_RC)) begin
                        ls_state_q <= CCG_LS_RC_RUN;
                        ls_cnt_q   <= 14'h0000;
                    end
                end
                CCG_LS_RC_RUN: if (xtal_ls_tick_in) begin
                    ls_cnt_q <= ls_cnt_q + 14'h0001;
                    if (ls_cnt_q + 14'h0001 >= 14'(LS_XTAL)) begin
                        ls_state_q <= CCG_LS_XTAL_RUN;
                    end
                end
                CCG_LS_XTAL_RUN: ls_state_q <= CCG_LS_XTAL_RUN;
                default:         ls_state_q <= CCG_LS_RC_WAIT;
            endcase
        end
    end

    assign ev_ls = !stop_q && ls_state_q == CCG_LS_RC_RUN && xtal_ls_tick_in
                   && ls_cnt_q + 14'h0001 >= 14'(LS_XTAL);

    // R11: flag follows change event
    // R12: stop sets flag silently
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || stop_q) begin
            ls_flag_q <= 1'b1;
        end else if (ev_ls) begin
            ls_flag_q <= 1'b0;
        end
    end

    // Set wins over the read clear
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            int_stat_q <= 2'h0;
        end else begin
            int_stat_q <= (rd_stat ? 2'h0 : int_stat_q) | {ev_hs, ev_ls};
        end
    end

    // ----------------------------------------
    // Clock outputs
    // ----------------------------------------
    // R18: source swaps only on old source edge
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            sys_src_q <= CCG_RST_OSCSEL[CCG_B_SYSSEL];
        // R7: stopped fast source has no edge to wait for
        end else if (sys_src_q != syssel_q
                     && (sys_src_q ? hs_link.out || !osc_ready_q : ls_tick_out)) begin
            sys_src_q <= syssel_q;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            osc_tick_out   <= 1'b0;
            ls_tick_out    <= 1'b0;
            sys_tick_out   <= 1'b0;
            hs_osc_run_out <= 1'b0;
            pll_en_out     <= 1'b0;
            pll_mult_out   <= CCG_PLL_MULT;
            irq_out        <= 1'b0;
        end else begin
            osc_tick_out   <= osc_pulse;
            ls_tick_out    <= ls_state_q == CCG_LS_XTAL_RUN ? xtal_ls_tick_in
                            : ls_state_q == CCG_LS_RC_RUN && rc_tick_in;
            sys_tick_out   <= sys_src_q ? hs_link.out : ls_tick_out;
            hs_osc_run_out <= run;
            // R16: PLL times 500
            pll_en_out     <= run && mode_q == CCG_MODE_PLL;
            pll_mult_out   <= CCG_PLL_MULT;
            irq_out        <= |(int_stat_q & int_mask_q);
        end
    end

    assign hs_tick_out  = hs_link.out;
    assign out_tick_out = out_link.out;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    mode_lock_a: assert property (hs_en_q |=> mode_q == $past(mode_q)) // R4
        else $error("mode changed while enabled");
    mode_legal_a: assert property (mode_q != CCG_MODE_BAD) // R3
        else $error("forbidden mode code");
    sel_forced_a: assert property (!hs_en_q |-> !syssel_q) // R7
        else $error("system select not held low");
    pll_half_a: assert property (mode_q == CCG_MODE_PLL |-> hs_link.sel != CCG_DIV_1) // R2
        else $error("undivided clock in PLL mode");
    stop_halt_a: assert property (stop_q |=> !hs_osc_run_out && !osc_ready_q) // R17
        else $error("oscillator runs in stop");
    flag_silent_a: assert property ($rose(ls_flag_q) |-> !$past(ev_ls)) // R12
        else $error("flag set raised change event");
    flag_event_a: assert property ($fell(ls_flag_q) |-> $past(ev_ls)) // R11
        else $error("flag fell without event");
    no_early_osc_a: assert property (!osc_ready_q |=> !osc_tick_out) // R14
        else $error("oscillation clock before ready");
    irq_level_a: assert property (|(int_stat_q & int_mask_q) |=> irq_out) // R15
        else $error("interrupt not raised");
    ready_read_a: assert property (setup && !pwrite_in && idx == CCG_IDX_OSCSEL
                                   |=> prdata_out[CCG_B_PLLRDY] == $past(osc_ready_q)) // R9
        else $error("ready flag readback wrong");

    ready_c:     cover property ($rose(osc_ready_q));
    ls_xtal_c:   cover property (ev_ls);
    src_swap_c:  cover property ($changed(sys_src_q));
    stop_wake_c: cover property ($fell(stop_q));

endmodule

/* testbench/ccg_osc_model.sv */
// Oscillator sources seen by the clock control block, as tick pulses.
// Assumes ref_clk_in is the block clock; ticks stop while their source is off.
`timescale 1ns/1ps
module ccg_osc_model (
    input  wire logic ref_clk_in,
    input  wire logic stop_mode_in,
    input  wire logic pll_en_in,
    input  wire logic hs_run_in,
    output logic      pll_tick_out,
    output logic      xtal_hs_tick_out,
    output logic      ext_tick_out,
    output logic      rc_tick_out,
    output logic      xtal_ls_tick_out
);
    // ----------------------------------------
    // Free-running phase counter
    // ----------------------------------------
    int unsigned n = 0;
    // ----------------------------------------
    // Sources, gated by their enables
    // ----------------------------------------
    // Periods of 2, 3, 2, 11 and 7 cycles; PLL and external ticks share period 2 at opposite phases
    always @(posedge ref_clk_in) begin
        n <= n + 1;
        pll_tick_out <= pll_en_in && (n % 2 == 0);
        xtal_hs_tick_out <= hs_run_in && (n % 3 == 0);
        ext_tick_out <= hs_run_in && (n % 2 == 1);
        rc_tick_out <= !stop_mode_in && (n % 11 == 0);
        xtal_ls_tick_out <= !stop_mode_in && (n % 7 == 3);
    end
endmodule

/* testbench/tb_ccg_top.sv */
// Self-checking bench for the clock generation control block.
// Assumes the oscillator model drives all tick inputs; APB master in here.
`timescale 1ns/1ps
module ccg_tb_per (
    input  wire logic ref_clk_in,
    input  wire logic base_in,
    input  wire logic tgt_in,
    output int        per_out
);
    // Base ticks counted between two target ticks; latency cancels out
    int cnt = 0;
    always @(posedge ref_clk_in) begin
        if (tgt_in) begin
            per_out <= cnt + int'(base_in);
            cnt <= 0;
        end else if (base_in) begin
            cnt <= cnt + 1;
        end
    end
endmodule

module tb_ccg_top;
    import ccg_pkg::*;
    logic              ref_clk = 1'b0;
    logic              rst = 1'b1;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [CCG_AW-1:0] paddr = '0;
    logic [31:0]       pwdata = '0;
    logic [31:0]       prdata;
    logic [31:0]       rdat;
    logic              pready, pslverr, rerr, stop = 1'b0;
    logic              t_pll, t_xhs, t_ext, t_rc, t_xls;
    logic              run, pll_en, osc_t, hs_t, out_t, ls_t, sys_t, irq;
    logic [9:0]        mult;
    logic [1:0]        mode_sel = CCG_MODE_PLL;
    int                n_errors = 0;
    int                n_compared = 0;
    int                src_cnt = 0;
    int                p_pll, p_hs, p_out, p_shs, p_sls;
    logic              seen = 1'b0;

    always #12.5 ref_clk = ~ref_clk;

    ccg_top #(.STAB_PLL(16), .STAB_XTAL(8), .LS_XTAL(16)) dut (
        .ref_clk_in(ref_clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .stop_mode_in(stop),
        .pll_tick_in(t_pll), .xtal_hs_tick_in(t_xhs), .ext_tick_in(t_ext),
        .rc_tick_in(t_rc), .xtal_ls_tick_in(t_xls), .hs_osc_run_out(run),
        .pll_en_out(pll_en), .pll_mult_out(mult), .osc_tick_out(osc_t),
        .hs_tick_out(hs_t), .out_tick_out(out_t), .ls_tick_out(ls_t),
        .sys_tick_out(sys_t), .irq_out(irq));
    ccg_osc_model osc (
        .ref_clk_in(ref_clk), .stop_mode_in(stop), .pll_en_in(pll_en), .hs_run_in(run),
        .pll_tick_out(t_pll), .xtal_hs_tick_out(t_xhs), .ext_tick_out(t_ext),
        .rc_tick_out(t_rc), .xtal_ls_tick_out(t_xls));
    ccg_tb_per m_pll (.ref_clk_in(ref_clk), .base_in(t_pll), .tgt_in(osc_t), .per_out(p_pll));
    ccg_tb_per m_hs (.ref_clk_in(ref_clk), .base_in(osc_t), .tgt_in(hs_t), .per_out(p_hs));
    ccg_tb_per m_out (.ref_clk_in(ref_clk), .base_in(osc_t), .tgt_in(out_t), .per_out(p_out));
    ccg_tb_per m_shs (.ref_clk_in(ref_clk), .base_in(hs_t), .tgt_in(sys_t), .per_out(p_shs));
    ccg_tb_per m_sls (.ref_clk_in(ref_clk), .base_in(ls_t), .tgt_in(sys_t), .per_out(p_sls));

    // ----------------------------------------
    // Source ticks seen before the first oscillation tick
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (run !== 1'b1) begin
            src_cnt <= 0;
            seen <= 1'b0;
        end else if (!seen) begin
            if (osc_t === 1'b1) seen <= 1'b1;
            else src_cnt <= src_cnt + int'((mode_sel == CCG_MODE_EXT) ? t_ext : t_xhs);
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic conclude;
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            n_errors++;
            conclude();
        end
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_rng(input int got, input int lo, input int hi);
        n_compared++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, lo);
        end
    endtask

    task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        cmp(rdat, {24'h0, exp});
    endtask

    // Polls the ready flag; a bounded number of reads
    task automatic wait_rdy;
        int k;
        k = 0;
        do begin
            apb(1'b0, CCG_IDX_OSCSEL, 8'h00);
            k++;
        end while (rdat[CCG_B_PLLRDY] !== 1'b1 && k < 300);
        if (k >= 300) begin
            n_errors++;
            conclude();
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [1:0] c;
        logic [7:0] v;
        int k;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rd(CCG_IDX_DIVMODE, 8'h3b);
        rd(CCG_IDX_OSCSEL, 8'h83);
        rd(CCG_IDX_STATUS, 8'h04);
        rd(CCG_IDX_INTSTAT, 8'h00);
        rd(CCG_IDX_INTMASK, 8'h00);
        apb(1'b0, 16'hf004, 8'h00);
        cmp({31'h0, rerr}, 32'h1);
        cmp(rdat, 32'h0);
        cmp({22'h0, mult}, 32'h1f4);
        cmp({31'h0, pll_en}, 32'h1);
        apb(1'b1, CCG_IDX_INTMASK, 8'h01);
        repeat (400) @(posedge ref_clk);
        cmp(p_pll, 32'h8);
        cmp(p_hs, 32'h8);
        cmp(p_shs, 32'h1);
        apb(1'b1, CCG_IDX_DIVMODE, 8'h37);
        rd(CCG_IDX_DIVMODE, 8'h3b);
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            apb(1'b1, CCG_IDX_DIVMODE, {2'b00, c, CCG_MODE_PLL, c});
            repeat (400) @(posedge ref_clk);
            cmp(p_hs, (i == 0) ? 32'h2 : 32'h1 << i);
            cmp(p_out, 32'h1 << i);
        end
        cmp({31'h0, irq}, 32'h1);
        rd(CCG_IDX_STATUS, 8'h00);
        rd(CCG_IDX_INTSTAT, 8'h01);
        repeat (2) @(posedge ref_clk);
        cmp({31'h0, irq}, 32'h0);
        apb(1'b1, CCG_IDX_OSCSEL, 8'h02);
        apb(1'b1, CCG_IDX_OSCSEL, 8'h01);
        rd(CCG_IDX_OSCSEL, 8'h00);
        cmp({31'h0, run}, 32'h0);
        repeat (100) @(posedge ref_clk);
        cmp(p_sls, 32'h1);
        apb(1'b1, CCG_IDX_DIVMODE, 8'h33);
        rd(CCG_IDX_DIVMODE, 8'h3b);
        for (int j = 0; j < 2; j++) begin
            mode_sel = (j == 0) ? CCG_MODE_XTAL : CCG_MODE_EXT;
            v = {4'h3, mode_sel, CCG_DIV_1};
            apb(1'b1, CCG_IDX_DIVMODE, v);
            rd(CCG_IDX_DIVMODE, v);
            apb(1'b1, CCG_IDX_OSCSEL, 8'h03);
            wait_rdy();
            cmp_rng(src_cnt, (j == 0) ? 8 : 128, (j == 0) ? 9 : 129);
            cmp({31'h0, irq}, 32'h0);
            rd(CCG_IDX_INTSTAT, 8'h02);
            repeat (60) @(posedge ref_clk);
            cmp(p_hs, 32'h1);
            cmp(p_shs, 32'h1);
            if (j == 0) begin
                apb(1'b1, CCG_IDX_OSCSEL, 8'h02);
                apb(1'b1, CCG_IDX_OSCSEL, 8'h00);
            end
        end
        stop <= 1'b1;
        repeat (10) @(posedge ref_clk);
        cmp({31'h0, run}, 32'h0);
        rd(CCG_IDX_STATUS, 8'h04);
        rd(CCG_IDX_INTSTAT, 8'h00);
        stop <= 1'b0;
        wait_rdy();
        cmp_rng(src_cnt, 128, 129);
        rd(CCG_IDX_INTSTAT, 8'h02);
        k = 0;
        while (irq !== 1'b1 && k < 4000) begin
            @(posedge ref_clk);
            k++;
        end
        cmp_rng(k, 0, 3999);
        rd(CCG_IDX_STATUS, 8'h00);
        rd(CCG_IDX_INTSTAT, 8'h01);
        conclude();
    end
endmodule
